// *** rss_core.sv ***
// execution datapath for rotate, subtract, skip, set, swap, table, xor
// assumes an ahb-lite master, a synchronous code memory with one cycle
// of read latency, and ce held high while the bus is active
//
// Our own choices: register access over AHB-Lite and the placing of the registers.
`timescale 1ns/1ps
`include "rss_params.svh"
module rss_core #(
   parameter int DMEM_DEPTH = 192,
   parameter int PMEM_AW = 12,
   parameter int PMEM_DW = 15
) (
   // clock, reset, enable
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic ce,
   // ahb-lite slave
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic hready,
   input wire logic [31:0] hwdata,
   output logic hreadyout,
   output logic [31:0] hrdata,
   output logic hresp,
   // code memory port
   output logic [PMEM_AW-1:0] pmem_addr,
   output logic pmem_rd,
   input wire logic [PMEM_DW-1:0] pmem_rdata,
   // core sequencing
   output logic busy,
   output logic skip_taken,
   output logic dummy_slot
);
   //--------------------------------------------------------------
   // elaboration checks and local sizes
   //--------------------------------------------------------------
   localparam int DAW = (DMEM_DEPTH > 1) ? $clog2(DMEM_DEPTH) : 1;
   localparam int PGW = PMEM_AW - 8; // page number width

   initial begin
      if (DMEM_DEPTH < 1 || DMEM_DEPTH > 256)
         $error("data memory depth must be 1 to 256");
      if (PMEM_AW < 9 || PMEM_AW > 16)
         $error("code address width must be 9 to 16");
      if (PMEM_DW < 9 || PMEM_DW > 16)
         $error("code word width must be 9 to 16");
   end

   //--------------------------------------------------------------
   // state
   //--------------------------------------------------------------
   logic [7:0] dmem [DMEM_DEPTH]; // on-chip data bytes
   rss_pkg::rss_state_e state_reg; // sequencer
   rss_pkg::rss_op_e op_reg; // latched operation
   logic [2:0] bit_reg; // selected bit index
   logic [7:0] imm_reg; // immediate constant
   logic [7:0] acc_reg; // accumulator
   logic carry_reg; // carry flag
   logic half_carry_flag_reg; // half carry flag
   logic zero_reg; // zero flag
   logic signed_wrap_flag_reg; // overflow flag
   logic [7:0] daddr_reg; // operand address
   logic [7:0] code_fetch_pointer_reg; // table pointer
   logic [7:0] code_fetch_high_byte_reg; // table high byte
   logic [PGW-1:0] page_reg; // current code page
   logic skip_reg; // last operation skipped
   logic [PMEM_AW-1:0] pmem_addr_reg; // code address out
   logic pmem_rd_reg; // code read strobe
   logic [7:0] aph_addr_reg; // captured bus address
   logic wr_reg; // write data phase pending
   logic rd_wait_reg; // read data phase wait
   logic [31:0] hrdata_reg; // read data

   //--------------------------------------------------------------
   // bus decode
   //--------------------------------------------------------------
   logic aph_take; // address phase accepted
   logic bus_wr; // write lands this cycle
   logic cmd_go; // command accepted
   logic idle; // sequencer free

   assign idle = (state_reg == rss_pkg::ST_IDLE);
   assign aph_take = hsel && htrans[1] && hready;
   // writes while busy are dropped so operands stay stable
   assign bus_wr = wr_reg && idle;
   assign cmd_go = bus_wr && (aph_addr_reg == `RSS_OFF_CMD);

   //--------------------------------------------------------------
   // operand fetch and arithmetic
   //--------------------------------------------------------------
   logic in_range; // address maps to a byte
   logic [7:0] operand; // data memory byte
   logic [7:0] bit_mask; // one-hot selected bit
   logic [7:0] sub_b; // subtrahend
   logic sub_bin; // borrow in
   logic [7:0] sub_d; // difference
   logic sub_c, sub_ac, sub_ov; // subtract flags
   logic [7:0] xor_val; // exclusive-or result
   logic [7:0] dec_val, inc_val; // step results

   assign in_range = (int'(daddr_reg) < DMEM_DEPTH);
   assign operand = in_range ? dmem[daddr_reg[DAW-1:0]] : `RSS_BYTE_RST;
   assign bit_mask = `RSS_ONE << bit_reg;
   assign sub_b = (op_reg == rss_pkg::OP_MINUS_IMM) ? imm_reg : operand;
   // borrow forms subtract the inverted carry
   assign sub_bin = ((op_reg == rss_pkg::OP_MINUS_WITH_BORROW) ||
      (op_reg == rss_pkg::OP_MINUS_WITH_BORROW_TO_MEM)) ?
      ~carry_reg : 1'b0;
   assign xor_val = acc_reg ^ ((op_reg == rss_pkg::OP_EXCLUSIVE_OR_IMM) ?
      imm_reg : operand);
   assign dec_val = operand - `RSS_ONE;
   assign inc_val = operand + `RSS_ONE;

   rss_sub u_sub (
      .minuend(acc_reg),
      .subtrahend(sub_b),
      .borrow_in(sub_bin),
      .diff(sub_d),
      .carry_out(sub_c),
      .half_out(sub_ac),
      .wrap_out(sub_ov)
   );

   //--------------------------------------------------------------
   // operation decode
   //--------------------------------------------------------------
   logic [7:0] res; // result byte
   logic mem_we, acc_we; // destinations
   logic c_we, c_val; // carry update
   logic arith_we; // overflow and half carry update
   logic z_we; // zero flag update
   logic skip_now; // skip decision
   logic table_op; // table read

   // one decode for all operations; unknown codes do nothing
   always_comb begin
      res = `RSS_BYTE_RST;
      mem_we = 1'b0;
      acc_we = 1'b0;
      c_we = 1'b0;
      c_val = carry_reg;
      arith_we = 1'b0;
      z_we = 1'b0;
      skip_now = 1'b0;
      table_op = 1'b0;
      case (op_reg)
         rss_pkg::OP_ROTL_IN_PLACE: begin
            res = {operand[6:0], operand[7]};
            mem_we = 1'b1;
         end
         rss_pkg::OP_ROTL_TO_ACCUM: begin
            res = {operand[6:0], operand[7]};
            acc_we = 1'b1;
         end
         rss_pkg::OP_ROTL_THROUGH_CARRY: begin
            res = {operand[6:0], carry_reg};
            mem_we = 1'b1;
            c_we = 1'b1;
            c_val = operand[7];
         end
         rss_pkg::OP_ROTL_CARRY_INTO_ACCUM: begin
            res = {operand[6:0], carry_reg};
            acc_we = 1'b1;
            c_we = 1'b1;
            c_val = operand[7];
         end
         rss_pkg::OP_ROTR_IN_PLACE: begin
            res = {operand[0], operand[7:1]};
            mem_we = 1'b1;
         end
         rss_pkg::OP_ROTR_INTO_ACCUM: begin
            res = {operand[0], operand[7:1]};
            acc_we = 1'b1;
         end
         rss_pkg::OP_ROTR_THROUGH_CARRY: begin
            res = {carry_reg, operand[7:1]};
            mem_we = 1'b1;
            c_we = 1'b1;
            c_val = operand[0];
         end
         rss_pkg::OP_ROTR_CARRY_INTO_ACCUM: begin
            res = {carry_reg, operand[7:1]};
            acc_we = 1'b1;
            c_we = 1'b1;
            c_val = operand[0];
         end
         rss_pkg::OP_MINUS_WITH_BORROW, rss_pkg::OP_MINUS,
         rss_pkg::OP_MINUS_IMM: begin
            res = sub_d;
            acc_we = 1'b1;
            c_we = 1'b1;
            c_val = sub_c;
            arith_we = 1'b1;
            z_we = 1'b1;
         end
         rss_pkg::OP_MINUS_WITH_BORROW_TO_MEM, rss_pkg::OP_MINUS_TO_MEM: begin
            res = sub_d;
            mem_we = 1'b1;
            c_we = 1'b1;
            c_val = sub_c;
            arith_we = 1'b1;
            z_we = 1'b1;
         end
         rss_pkg::OP_DEC_SKIP_ZERO: begin
            res = dec_val;
            mem_we = 1'b1;
            skip_now = (dec_val == `RSS_BYTE_RST);
         end
         rss_pkg::OP_DEC_SKIP_ZERO_ACCUM: begin
            res = dec_val;
            acc_we = 1'b1;
            skip_now = (dec_val == `RSS_BYTE_RST);
         end
         rss_pkg::OP_INC_SKIP_ZERO: begin
            res = inc_val;
            mem_we = 1'b1;
            skip_now = (inc_val == `RSS_BYTE_RST);
         end
         rss_pkg::OP_INC_SKIP_ZERO_ACCUM: begin
            res = inc_val;
            acc_we = 1'b1;
            skip_now = (inc_val == `RSS_BYTE_RST);
         end
         rss_pkg::OP_SET_BYTE: begin
            res = `RSS_BYTE_ONES;
            mem_we = 1'b1;
         end
         rss_pkg::OP_SET_BIT: begin
            res = operand | bit_mask;
            mem_we = 1'b1;
         end
         rss_pkg::OP_SKIP_BIT_SET:
            skip_now = |(operand & bit_mask);
         rss_pkg::OP_SKIP_IF_NULL:
            skip_now = (operand == `RSS_BYTE_RST);
         rss_pkg::OP_COPY_SKIP_IF_NULL: begin
            res = operand;
            acc_we = 1'b1;
            skip_now = (operand == `RSS_BYTE_RST);
         end
         rss_pkg::OP_SKIP_BIT_CLEAR:
            skip_now = ~|(operand & bit_mask);
         rss_pkg::OP_NIBBLE_EXCHANGE: begin
            res = {operand[3:0], operand[7:4]};
            mem_we = 1'b1;
         end
         rss_pkg::OP_NIBBLE_EXCHANGE_TO_ACCUM: begin
            res = {operand[3:0], operand[7:4]};
            acc_we = 1'b1;
         end
         rss_pkg::OP_FETCH_CODE_CUR_PAGE, rss_pkg::OP_FETCH_CODE_LAST_PAGE:
            table_op = 1'b1;
         rss_pkg::OP_EXCLUSIVE_OR, rss_pkg::OP_EXCLUSIVE_OR_IMM: begin
            res = xor_val;
            acc_we = 1'b1;
            z_we = 1'b1;
         end
         rss_pkg::OP_EXCLUSIVE_OR_TO_MEM: begin
            res = xor_val;
            mem_we = 1'b1;
            z_we = 1'b1;
         end
         default: ;
      endcase
   end

   logic exec; // execute cycle
   assign exec = (state_reg == rss_pkg::ST_EXEC);

   //--------------------------------------------------------------
   // sequencer
   //--------------------------------------------------------------
   // idle, execute, optional table fetch or dummy slot
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         state_reg <= rss_pkg::ST_IDLE;
      end else if (ce) begin
         case (state_reg)
            rss_pkg::ST_IDLE:
               if (cmd_go) state_reg <= rss_pkg::ST_EXEC;
            rss_pkg::ST_EXEC:
               if (table_op) state_reg <= rss_pkg::ST_TFETCH;
               else if (skip_now) state_reg <= rss_pkg::ST_DUMMY;
               else state_reg <= rss_pkg::ST_IDLE;
            rss_pkg::ST_TFETCH: state_reg <= rss_pkg::ST_TLOAD;
            default: state_reg <= rss_pkg::ST_IDLE;
         endcase
      end
   end

   // command latch: opcode, bit index, immediate
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         op_reg <= rss_pkg::OP_NOP;
         bit_reg <= 3'h0;
         imm_reg <= `RSS_BYTE_RST;
      end else if (ce && cmd_go) begin
         op_reg <= rss_pkg::rss_op_e'(hwdata[`RSS_CMD_OP_LSB +: 6]);
         bit_reg <= hwdata[`RSS_CMD_BIT_LSB +: 3];
         imm_reg <= hwdata[`RSS_CMD_IMM_LSB +: 8];
      end
   end

   // skip status, held until the next command
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) skip_reg <= 1'b0;
      else if (ce && exec) skip_reg <= skip_now;
   end

   //--------------------------------------------------------------
   // data memory, accumulator, flags
   //--------------------------------------------------------------
   // execution writes, table low byte, or bus byte access
   always_ff @(posedge hclk) begin
      if (ce && in_range) begin
         if (exec && mem_we)
            dmem[daddr_reg[DAW-1:0]] <= res;
         else if (state_reg == rss_pkg::ST_TLOAD)
            dmem[daddr_reg[DAW-1:0]] <= pmem_rdata[7:0];
         else if (bus_wr && aph_addr_reg == `RSS_OFF_DDATA)
            dmem[daddr_reg[DAW-1:0]] <= hwdata[7:0];
      end
   end

   // accumulator
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) acc_reg <= `RSS_ACC_RST;
      else if (ce) begin
         if (exec && acc_we) acc_reg <= res;
         else if (bus_wr && aph_addr_reg == `RSS_OFF_ACC)
            acc_reg <= hwdata[7:0];
      end
   end

   // status flags; execution updates only the flags it owns
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         carry_reg <= 1'b0;
         half_carry_flag_reg <= 1'b0;
         zero_reg <= 1'b0;
         signed_wrap_flag_reg <= 1'b0;
      end else if (ce) begin
         if (exec) begin
            if (c_we) carry_reg <= c_val;
            if (arith_we) begin
               half_carry_flag_reg <= sub_ac;
               signed_wrap_flag_reg <= sub_ov;
            end
            if (z_we) zero_reg <= (res == `RSS_BYTE_RST);
         end else if (bus_wr && aph_addr_reg == `RSS_OFF_FLAGS) begin
            carry_reg <= hwdata[`RSS_FLAG_C];
            half_carry_flag_reg <= hwdata[`RSS_FLAG_AC];
            zero_reg <= hwdata[`RSS_FLAG_Z];
            signed_wrap_flag_reg <= hwdata[`RSS_FLAG_OV];
         end
      end
   end

   // operand address, table pointer and page
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         daddr_reg <= `RSS_BYTE_RST;
         code_fetch_pointer_reg <= `RSS_BYTE_RST;
         page_reg <= '0;
      end else if (ce && bus_wr) begin
         if (aph_addr_reg == `RSS_OFF_DADDR)
            daddr_reg <= hwdata[7:0];
         else if (aph_addr_reg == `RSS_OFF_PTR)
            code_fetch_pointer_reg <= hwdata[7:0];
         else if (aph_addr_reg == `RSS_OFF_PAGE)
            page_reg <= hwdata[PGW-1:0];
      end
   end

   //--------------------------------------------------------------
   // table read
   //--------------------------------------------------------------
   // address issued at execute, word captured two cycles later
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         pmem_addr_reg <= '0;
         pmem_rd_reg <= 1'b0;
      end else if (ce) begin
         pmem_rd_reg <= exec && table_op;
         if (exec && op_reg == rss_pkg::OP_FETCH_CODE_CUR_PAGE)
            pmem_addr_reg <= {page_reg, code_fetch_pointer_reg};
         else if (exec && op_reg == rss_pkg::OP_FETCH_CODE_LAST_PAGE)
            pmem_addr_reg <= {{PGW{1'b1}}, code_fetch_pointer_reg};
      end
   end

   // high byte of the code word
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) code_fetch_high_byte_reg <= `RSS_BYTE_RST;
      else if (ce && state_reg == rss_pkg::ST_TLOAD)
         code_fetch_high_byte_reg <= 8'(pmem_rdata >> 8);
   end

   //--------------------------------------------------------------
   // bus slave
   //--------------------------------------------------------------
   logic [31:0] rd_mux; // read data select

   // reads take one wait state, writes none
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         aph_addr_reg <= `RSS_BYTE_RST;
         wr_reg <= 1'b0;
         rd_wait_reg <= 1'b0;
      end else if (ce) begin
         if (rd_wait_reg) begin
            rd_wait_reg <= 1'b0;
         end else begin
            wr_reg <= aph_take && hwrite;
            rd_wait_reg <= aph_take && !hwrite;
            if (aph_take) aph_addr_reg <= haddr[7:0];
         end
      end
   end

   // register read select; unmapped offsets read zero
   always_comb begin
      rd_mux = 32'h0000_0000;
      if (aph_addr_reg == `RSS_OFF_CMD)
         rd_mux = {8'h00, imm_reg, 5'h00, bit_reg, 2'h0, op_reg};
      else if (aph_addr_reg == `RSS_OFF_ACC)
         rd_mux[7:0] = acc_reg;
      else if (aph_addr_reg == `RSS_OFF_FLAGS)
         rd_mux[3:0] = {signed_wrap_flag_reg, zero_reg,
            half_carry_flag_reg, carry_reg};
      else if (aph_addr_reg == `RSS_OFF_DADDR)
         rd_mux[7:0] = daddr_reg;
      else if (aph_addr_reg == `RSS_OFF_DDATA)
         rd_mux[7:0] = operand;
      else if (aph_addr_reg == `RSS_OFF_PTR)
         rd_mux[7:0] = code_fetch_pointer_reg;
      else if (aph_addr_reg == `RSS_OFF_HIGH)
         rd_mux[7:0] = code_fetch_high_byte_reg;
      else if (aph_addr_reg == `RSS_OFF_PAGE)
         rd_mux[PGW-1:0] = page_reg;
      else if (aph_addr_reg == `RSS_OFF_STATUS) begin
         rd_mux[`RSS_STAT_BUSY] = !idle;
         rd_mux[`RSS_STAT_SKIP] = skip_reg;
         rd_mux[`RSS_STAT_DUMMY] = (state_reg == rss_pkg::ST_DUMMY);
      end
   end

   // read data captured in the wait cycle
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) hrdata_reg <= 32'h0000_0000;
      else if (ce && rd_wait_reg) hrdata_reg <= rd_mux;
   end

   //--------------------------------------------------------------
   // outputs
   //--------------------------------------------------------------
   // a write is stretched while the clock enable is low
   assign hreadyout = !rd_wait_reg && (ce || !wr_reg);
   assign hrdata = hrdata_reg;
   assign hresp = 1'b0;
   assign pmem_addr = pmem_addr_reg;
   assign pmem_rd = pmem_rd_reg;
   assign busy = !idle;
   assign skip_taken = skip_reg;
   assign dummy_slot = (state_reg == rss_pkg::ST_DUMMY);

endmodule // rss_core

// *** rss_params.svh ***
// constants of the rotate/subtract/skip datapath: offsets, fields, resets
// assumes inclusion by bare name from every file that decodes registers
`ifndef RSS_PARAMS_SVH
`define RSS_PARAMS_SVH

// register byte offsets on the bus
`define RSS_OFF_CMD    8'h00
`define RSS_OFF_ACC    8'h04
`define RSS_OFF_FLAGS  8'h08
`define RSS_OFF_DADDR  8'h0C
`define RSS_OFF_DDATA  8'h10
`define RSS_OFF_PTR    8'h14
`define RSS_OFF_HIGH   8'h18
`define RSS_OFF_PAGE   8'h1C
`define RSS_OFF_STATUS 8'h20

// command word fields
`define RSS_CMD_OP_LSB  0
`define RSS_CMD_BIT_LSB 8
`define RSS_CMD_IMM_LSB 16

// flag register bit positions
`define RSS_FLAG_C  0
`define RSS_FLAG_AC 1
`define RSS_FLAG_Z  2
`define RSS_FLAG_OV 3

// status register bit positions
`define RSS_STAT_BUSY  0
`define RSS_STAT_SKIP  1
`define RSS_STAT_DUMMY 2

// reset values and constants
`define RSS_ACC_RST   8'h00
`define RSS_BYTE_RST  8'h00
`define RSS_BYTE_ONES 8'hFF
`define RSS_ONE       8'h01

`endif

// *** rss_pkg.sv ***
// types of the rotate/subtract/skip datapath: operation codes, states
// assumes nothing of its surroundings
package rss_pkg;

   // operation codes, numbered 0 upward in this order
   typedef enum logic [5:0] {
      OP_NOP,
      OP_ROTL_IN_PLACE,
      OP_ROTL_TO_ACCUM,
      OP_ROTL_THROUGH_CARRY,
      OP_ROTL_CARRY_INTO_ACCUM,
      OP_ROTR_IN_PLACE,
      OP_ROTR_INTO_ACCUM,
      OP_ROTR_THROUGH_CARRY,
      OP_ROTR_CARRY_INTO_ACCUM,
      OP_MINUS_WITH_BORROW,
      OP_MINUS_WITH_BORROW_TO_MEM,
      OP_MINUS,
      OP_MINUS_TO_MEM,
      OP_MINUS_IMM,
      OP_DEC_SKIP_ZERO,
      OP_DEC_SKIP_ZERO_ACCUM,
      OP_INC_SKIP_ZERO,
      OP_INC_SKIP_ZERO_ACCUM,
      OP_SET_BYTE,
      OP_SET_BIT,
      OP_SKIP_BIT_SET,
      OP_SKIP_IF_NULL,
      OP_COPY_SKIP_IF_NULL,
      OP_SKIP_BIT_CLEAR,
      OP_NIBBLE_EXCHANGE,
      OP_NIBBLE_EXCHANGE_TO_ACCUM,
      OP_FETCH_CODE_CUR_PAGE,
      OP_FETCH_CODE_LAST_PAGE,
      OP_EXCLUSIVE_OR,
      OP_EXCLUSIVE_OR_TO_MEM,
      OP_EXCLUSIVE_OR_IMM
   } rss_op_e;

   // execution sequencer states
   typedef enum logic [2:0] {
      ST_IDLE,
      ST_EXEC,
      ST_TFETCH,
      ST_TLOAD,
      ST_DUMMY
   } rss_state_e;

endpackage

// *** rss_sub.sv ***
// eight-bit subtractor with borrow and flag outputs
// assumes purely combinational use by the datapath
`timescale 1ns/1ps
module rss_sub (
   // operands
   input wire logic [7:0] minuend,
   input wire logic [7:0] subtrahend,
   input wire logic borrow_in,
   // result and flags
   output logic [7:0] diff,
   output logic carry_out,
   output logic half_out,
   output logic wrap_out
);
   logic [8:0] full; // nine-bit difference, msb is borrow
   logic [4:0] low; // low nibble difference for half carry

   assign full = {1'b0, minuend} - {1'b0, subtrahend} - {8'h00, borrow_in};
   assign low = {1'b0, minuend[3:0]} - {1'b0, subtrahend[3:0]}
      - {4'h0, borrow_in};
   assign diff = full[7:0];
   // carry is clear on a negative result, set on zero or positive
   assign carry_out = ~full[8];
   assign half_out = ~low[4];
   // signed wrap when signs differ and result sign leaves minuend's
   assign wrap_out = (minuend[7] != subtrahend[7]) &&
      (full[7] != minuend[7]);
endmodule // rss_sub

// *** rss_pmem.sv ***
// code memory model: each word is a fixed function of its address
// assumes a read pulse one cycle before the core samples the word
`timescale 1ns/1ps
module rss_pmem(
   input wire logic hclk,
   input wire logic pmem_rd,
   input wire logic [11:0] pmem_addr,
   output logic [14:0] pmem_rdata
);
   // answer one cycle after the pulse, then show a wrong word
   always_ff @(posedge hclk)
      pmem_rdata <= pmem_rd ? 15'(pmem_addr*13+7) : ~15'(pmem_addr*13+7);
endmodule // rss_pmem

// *** rss_core_chk.sv ***
// port checker of the datapath core
// assumes ce is never held low for more than one cycle at a time
`timescale 1ns/1ps
module rss_core_chk(
   input wire logic hclk,hresetn,ce,hsel,hwrite,hready,hreadyout,
   input wire logic pmem_rd,busy,skip_taken,dummy_slot,
   input wire logic [1:0] htrans
);
   default clocking @(posedge hclk); endclocking
   default disable iff (!hresetn);
   wire rq=hsel&&htrans[1]&&hready&&ce;
   rd_wait_a: assert property(rq&&!hwrite|=>!hreadyout##1 hreadyout)
      else $error("read wait");
   wr_fast_a: assert property(rq&&hwrite|=>hreadyout) else $error("wr wait");
   skip_dummy_a: assert property($rose(skip_taken)|->dummy_slot)
      else $error("no dummy");
   dummy_one_a: assert property(dummy_slot|=>!dummy_slot)
      else $error("long dummy");
   dummy_why_a: assert property($rose(dummy_slot)|->skip_taken&&busy)
      else $error("stray dummy");
   fetch_pulse_a: assert property(pmem_rd|=>!pmem_rd)
      else $error("long fetch");
   fetch_busy_a: assert property(pmem_rd|->busy[*2])
      else $error("fetch idle");
   busy_end_a: assert property($rose(busy)|->##[1:4]!busy)
      else $error("stuck busy");
   skip_c: cover property(dummy_slot);
   fetch_c: cover property(pmem_rd);
   read_c: cover property(rq&&!hwrite);
endmodule // rss_core_chk
bind rss_core rss_core_chk u_chk(.*);

// *** test_mcu_rotate_sub_skip_xor_ops.sv ***
// bench: random sweep of every opcode against an integer model
// assumes default core parameters and one bus slave
`timescale 1ns/1ps
module test_mcu_rotate_sub_skip_xor_ops;
   logic hclk=0,hresetn=0,hsel=0,hwrite=0,hreadyout,hresp,pmem_rd;
   logic busy,skip_taken,dummy_slot,ce=1;
   logic [1:0] htrans=0;
   logic [31:0] haddr=0,hwdata=0,hrdata,d;
   logic [11:0] pmem_addr;
   logic [14:0] pmem_rdata;
   int fail_count=0,samples_checked=0,seed=56195;
   int a,m,f,w,x,op,i,k,n,r,bw,ea,em,ef,eh=0,sk,b,s,da,pg;
   rss_core u_dut(.hsize(3'h2),.hready(hreadyout),.*);
   rss_pmem u_mem(.*);
   initial forever #12.5 hclk=~hclk;
   task automatic wrap_up;
      $display("checks %0d errors %0d",samples_checked,fail_count);
      if(fail_count==0&&samples_checked>0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask
   // one bus phase, sampled mid-cycle to stay clear of the edge
   task automatic wt;
      logic y;
      k=0;
      do begin
         @(negedge hclk);
         y=hreadyout;
         d=hrdata;
         @(posedge hclk);
         k++;
      end while(y!==1'b1&&k<40);
      if(y!==1'b1) begin
         fail_count++;
         wrap_up;
      end
   endtask
   task automatic bus(input logic wr,input logic [7:0] ad,input int wd);
      htrans<=2'h2; hsel<=1; hwrite<=wr; haddr<={24'h0,ad};
      wt;
      htrans<=2'h0; hwdata<=wd;
      wt;
   endtask
   task automatic rd(input logic [7:0] ad,input int e);
      bus(0,ad,0);
      samples_checked++;
      if(d!==32'(e)) begin
         fail_count++;
         $display("ERROR %0t %h %h",$time,d,32'(e));
      end
   endtask
   initial begin
      repeat(2) @(posedge hclk);
      hresetn<=1;
      for(i=0;i<62;i++) begin
         op=i%31; w=$random(seed); x=$random(seed);
         a=w&255; f=w>>8&15; da=w>>12&127; pg=w>>20&15;
         m=x&255; b=x>>8&7; s=x>>16&255;
         // second pass: boundary operands
         if(i>30) m=op inside{14,15}?1:op inside{16,17}?255:op<14?a:0;
         bus(1,8'h08,f); bus(1,8'h04,a); bus(1,8'h0C,da);
         bus(1,8'h10,m); bus(1,8'h14,a); bus(1,8'h1C,pg);
         bus(1,8'h00,x&32'h00FF0700|op);
         // freeze the execute cycle once: the op must still be pending
         ce<=0;
         @(posedge hclk);
         ce<=1;
         @(negedge hclk);
         samples_checked++;
         if(busy!==1'b1) begin
            fail_count++;
            $display("ERROR %0t %h %h",$time,busy,1'b1);
         end
         @(posedge hclk);
         n=0;
         do bus(0,8'h20,0); while(d[0]!==1'b0&&++n<20);
         // a core that never goes idle is a failure, not a hang
         if(d[0]!==1'b0) begin
            fail_count++;
            wrap_up;
         end
         ea=a; em=m; ef=f; sk=0;
         r=op==13||op==30?s:m;
         bw=op==9||op==10?~f&1:0;
         case(op)
            1: em=(m<<1|m>>7)&255;
            2: ea=(m<<1|m>>7)&255;
            3,4: begin
               r=(m<<1|f&1)&255; ef=f&14|m>>7;
               if(op==3) em=r; else ea=r;
            end
            5,6: begin
               r=m>>1|(m&1)<<7;
               if(op==5) em=r; else ea=r;
            end
            7,8: begin
               r=m>>1|(f&1)<<7; ef=f&14|m&1;
               if(op==7) em=r; else ea=r;
            end
            9,10,11,12,13: begin
               k=a-r-bw; ef=k>=0;
               if((a&15)-(r&15)-bw>=0) ef+=2;
               if(!(k&255)) ef+=4;
               if((a^r)&(a^k)&128) ef+=8;
               if(op==10||op==12) em=k&255; else ea=k&255;
            end
            14,15,16,17: begin
               k=(op<16?m-1:m+1)&255; sk=k==0;
               if(op&1) ea=k; else em=k;
            end
            18: em=255;
            19: em=m|1<<b;
            20,23: sk=(m>>b&1)==(op==20);
            21: sk=m==0;
            22: begin ea=m; sk=m==0; end
            24: em=m>>4|m<<4&255;
            25: ea=m>>4|m<<4&255;
            26,27: begin
               k=((op==26?pg:15)<<8|a)*13+7; em=k&255; eh=k>>8&127;
            end
            28,29,30: begin
               k=a^r; ef=f&11|(k?0:4);
               if(op==29) em=k; else ea=k;
            end
            default: ;
         endcase
         rd(8'h20,sk*2);
         rd(8'h04,ea);
         rd(8'h08,ef);
         rd(8'h10,em);
         rd(8'h18,eh);
      end
      wrap_up;
   end
endmodule // test_mcu_rotate_sub_skip_xor_ops
